//--- logic/fsps_regs.vh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * flash self-programming sequencer.
 * Assumes inclusion by its bare name from design files under logic/.
 */
`ifndef FSPS_REGS_VH
`define FSPS_REGS_VH

`define FSPS_OFF_CTRL      8'h00
`define FSPS_OFF_KEY       8'h04
`define FSPS_OFF_TPSEL     8'h08
`define FSPS_OFF_ADDR      8'h0c
`define FSPS_OFF_WDATA     8'h10
`define FSPS_OFF_TBLCMD    8'h14
`define FSPS_OFF_RDATA     8'h18
`define FSPS_OFF_STATUS    8'h1c
`define FSPS_OFF_FDATA     8'h20
`define FSPS_OFF_FCMD      8'h24

`define FSPS_CTRL_GO       15
`define FSPS_CTRL_WEN      14
`define FSPS_CTRL_SERR     13
`define FSPS_CTRL_ERASE    6
`define FSPS_CTRL_RESET    32'h0000_0000

`define FSPS_KEY_FIRST     8'h55
`define FSPS_KEY_SECOND    8'haa

`define FSPS_OP_BULK       4'hf
`define FSPS_OP_PAGE       4'h2
`define FSPS_OP_WORD       4'h3
`define FSPS_OP_ROW        4'h1

`define FSPS_CMD_WRITE     0
`define FSPS_CMD_HIGH      1
`define FSPS_CMD_BYTE      2

`define FSPS_ROW_WORDS     64
`define FSPS_PAGE_ROWS     8
`define FSPS_ROW_OSC_CYC   11064
`define FSPS_OSC_KHZ       7370
`define FSPS_CLK_KHZ       40000
`define FSPS_TBLWT_CYC     2

`endif

//--- logic/fsps_buf.v
/*
 * Holding buffer of program words with per-lane write enables and a
 * registered read port.
 * Assumes a single clock; read data appear one cycle after the address.
 */
`timescale 1ns/1ps
`default_nettype none

module fsps_buf #(
    parameter DEPTH = 64,
    parameter AW    = 6
) (
    input  wire          clk,
    input  wire [AW-1:0] waddr,
    input  wire [2:0]    wen,
    input  wire [23:0]   wdata,
    input  wire [AW-1:0] raddr,
    output reg  [23:0]   rdata
);
    reg [23:0] mem [0:DEPTH-1];
    genvar g;

    generate
        for (g = 0; g < 3; g = g + 1) begin : lane
            always @(posedge clk) begin
                if (wen[g]) begin
                    mem[waddr][g*8 +: 8] <= wdata[g*8 +: 8];
                end
            end
        end
    endgenerate

    always @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule

`default_nettype wire

//--- logic/fsps_top.v
/*
 * Run-time flash self-programming sequencer: holding buffer loaded by table
 * writes, unlock-guarded control register, timed row, word and page
 * operations against a simple flash array port, and a core stall output.
 * Assumes an AXI4-Lite master on CLK and an array that accepts writes and
 * erases on its port while the sequencer holds the operation active.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fsps_regs.vh"

module fsps_top #(
    parameter ROW_CYC  = (`FSPS_ROW_OSC_CYC * (`FSPS_CLK_KHZ / 10) + (`FSPS_OSC_KHZ / 10) - 1)
                         / (`FSPS_OSC_KHZ / 10),
    parameter WORD_CYC = ROW_CYC / 16,
    parameter PAGE_CYC = ROW_CYC * 2,
    parameter BULK_CYC = ROW_CYC * 4
) (
    input  wire        CLK,
    input  wire        RSTN,
    input  wire [7:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [7:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY,
    output reg         CORE_STALL,
    output reg         FLASH_WR,
    output reg         FLASH_ERASE,
    output reg  [23:0] FLASH_ADDR,
    output reg  [23:0] FLASH_DATA,
    output reg  [23:0] FLASH_ERASE_LEN
);
    localparam ST_IDLE = 3'd0;
    localparam ST_PROG = 3'd1;
    localparam ST_ERAS = 3'd2;
    localparam ST_WAIT = 3'd3;
    localparam ST_DONE = 3'd4;

    reg  [7:0]  aw_addr_reg;
    reg         aw_have_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg         w_have_reg;
    reg         go_reg, wen_reg, serr_reg, erase_reg;
    reg  [3:0]  opsel_reg;
    reg  [1:0]  key_stage_reg;
    reg  [7:0]  page_reg;
    reg  [15:0] ea_reg;
    reg  [15:0] wdat_reg;
    reg  [23:0] rdat_reg;
    reg  [23:0] fdat_reg;
    reg  [2:0]  state_reg;
    reg  [31:0] cnt_reg;
    reg  [6:0]  idx_reg;
    reg         tbl_busy_reg;
    reg  [2:0]  buf_wen;
    reg  [23:0] buf_wdata;
    wire [23:0] buf_rdata;
    wire [23:0] tgt_addr = {page_reg, ea_reg};
    wire        wr_fire = aw_have_reg && w_have_reg && !S_AXI_BVALID;
    wire        lane0 = w_strb_reg[0];
    wire        lane1 = w_strb_reg[1];
    wire [1:0]  rd_lo = (S_AXI_ARADDR == `FSPS_OFF_CTRL) ? 2'd1 : 2'd0;

    fsps_buf #(.DEPTH(`FSPS_ROW_WORDS), .AW(6)) u_buf (
        .clk   (CLK),
        .waddr (ea_reg[6:1]),
        .wen   (buf_wen),
        .wdata (buf_wdata),
        .raddr (idx_reg[5:0]),
        .rdata (buf_rdata)
    );

    // Table write command lanes: low word, low byte or phantom-free high byte.
    always @* begin
        buf_wen   = 3'b000;
        buf_wdata = {wdat_reg[7:0], wdat_reg};
        if (wr_fire && aw_addr_reg == `FSPS_OFF_TBLCMD && lane0
            && w_data_reg[`FSPS_CMD_WRITE]) begin
            if (w_data_reg[`FSPS_CMD_HIGH]) begin
                if (!w_data_reg[`FSPS_CMD_BYTE] || !ea_reg[0]) begin
                    buf_wen = 3'b100;
                end
            end else if (w_data_reg[`FSPS_CMD_BYTE]) begin
                buf_wen   = ea_reg[0] ? 3'b010 : 3'b001;
                buf_wdata = {wdat_reg[7:0], wdat_reg[7:0], wdat_reg[7:0]};
            end else begin
                buf_wen = 3'b011;
            end
        end
    end

    // Write channel: address and data are held until both have arrived.
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            aw_have_reg   <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_have_reg    <= 1'b0;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= 2'b00;
        end else begin
            S_AXI_AWREADY <= !aw_have_reg && !S_AXI_AWREADY && S_AXI_AWVALID;
            S_AXI_WREADY  <= !w_have_reg && !S_AXI_WREADY && S_AXI_WVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have_reg <= 1'b1;
                w_data_reg <= S_AXI_WDATA;
                w_strb_reg <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (aw_addr_reg[1:0] == 2'b00 && aw_addr_reg <= `FSPS_OFF_FCMD)
                                ? 2'b00 : 2'b10;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Register writes, unlock sequencing and the operation sequencer.
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            go_reg        <= 1'b0;
            wen_reg       <= 1'b0;
            serr_reg      <= 1'b0;
            erase_reg     <= 1'b0;
            opsel_reg     <= 4'h0;
            key_stage_reg <= 2'd0;
            page_reg      <= 8'h00;
            ea_reg        <= 16'h0000;
            wdat_reg      <= 16'h0000;
            rdat_reg      <= 24'h000000;
            fdat_reg      <= 24'h000000;
            state_reg     <= ST_IDLE;
            cnt_reg       <= 32'd0;
            idx_reg       <= 7'd0;
            tbl_busy_reg  <= 1'b0;
            CORE_STALL    <= 1'b0;
            FLASH_WR      <= 1'b0;
            FLASH_ERASE   <= 1'b0;
            FLASH_ADDR    <= 24'h000000;
            FLASH_DATA    <= 24'h000000;
            FLASH_ERASE_LEN <= 24'h000000;
        end else begin
            FLASH_WR     <= 1'b0;
            FLASH_ERASE  <= 1'b0;
            tbl_busy_reg <= 1'b0;
            if (|buf_wen) begin
                tbl_busy_reg <= 1'b1;
            end
            if (wr_fire && lane0) begin
                if (aw_addr_reg == `FSPS_OFF_KEY) begin
                    if (w_data_reg[7:0] == `FSPS_KEY_FIRST) begin
                        key_stage_reg <= 2'd1;
                    end else if (w_data_reg[7:0] == `FSPS_KEY_SECOND
                                 && key_stage_reg == 2'd1) begin
                        key_stage_reg <= 2'd2;
                    end else begin
                        key_stage_reg <= 2'd0;
                    end
                end else if (aw_addr_reg == `FSPS_OFF_CTRL) begin
                    key_stage_reg <= 2'd0;
                    if (!go_reg) begin
                        erase_reg <= w_data_reg[`FSPS_CTRL_ERASE];
                        opsel_reg <= w_data_reg[3:0];
                    end
                    if (lane1) begin
                        if (!go_reg) begin
                            wen_reg <= w_data_reg[`FSPS_CTRL_WEN];
                        end
                        if (w_data_reg[`FSPS_CTRL_GO] && !go_reg) begin
                            if (key_stage_reg == 2'd2 && w_data_reg[`FSPS_CTRL_WEN]) begin
                                go_reg <= 1'b1;
                                serr_reg <= 1'b0;
                            end else begin
                                serr_reg <= 1'b1;
                            end
                        end else if (!w_data_reg[`FSPS_CTRL_SERR]) begin
                            serr_reg <= 1'b0;
                        end
                    end
                end else begin
                    key_stage_reg <= 2'd0;
                    case (aw_addr_reg)
                        `FSPS_OFF_TPSEL:  page_reg <= w_data_reg[7:0];
                        `FSPS_OFF_ADDR:   ea_reg <= w_data_reg[15:0];
                        `FSPS_OFF_WDATA:  wdat_reg <= w_data_reg[15:0];
                        `FSPS_OFF_FDATA:  fdat_reg <= w_data_reg[23:0];
                        default:          ea_reg <= ea_reg;
                    endcase
                end
            end
            case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= 32'd0;
                    idx_reg <= 7'd0;
                    if (go_reg) begin
                        CORE_STALL <= 1'b1;
                        if (!wen_reg) begin
                            state_reg <= ST_DONE;
                        end else if (erase_reg && (opsel_reg == `FSPS_OP_PAGE
                                     || opsel_reg == `FSPS_OP_BULK)) begin
                            state_reg <= ST_ERAS;
                        end else if (!erase_reg && (opsel_reg == `FSPS_OP_ROW
                                     || opsel_reg == `FSPS_OP_WORD)) begin
                            state_reg <= ST_PROG;
                        end else begin
                            state_reg <= ST_DONE;
                        end
                    end
                end
                ST_ERAS: begin
                    FLASH_ERASE <= 1'b1;
                    if (opsel_reg == `FSPS_OP_BULK) begin
                        FLASH_ADDR      <= 24'h000000;
                        FLASH_ERASE_LEN <= 24'hffffff;
                    end else begin
                        // Page base: word index rounded down to 512 words.
                        FLASH_ADDR      <= {tgt_addr[23:10], 10'h000};
                        FLASH_ERASE_LEN <= 24'd1024;
                    end
                    state_reg <= ST_WAIT;
                    cnt_reg   <= (opsel_reg == `FSPS_OP_BULK) ? BULK_CYC : PAGE_CYC;
                end
                ST_PROG: begin
                    if (opsel_reg == `FSPS_OP_WORD) begin
                        FLASH_WR   <= 1'b1;
                        FLASH_ADDR <= {tgt_addr[23:1], 1'b0};
                        FLASH_DATA <= fdat_reg;
                        state_reg  <= ST_WAIT;
                        cnt_reg    <= WORD_CYC;
                    end else begin
                        // Buffer read lags the index by one cycle.
                        idx_reg <= idx_reg + 7'd1;
                        if (idx_reg != 7'd0) begin
                            FLASH_WR   <= 1'b1;
                            FLASH_ADDR <= {tgt_addr[23:7], idx_reg[5:0] - 6'd1, 1'b0};
                            FLASH_DATA <= buf_rdata;
                        end
                        if (idx_reg == 7'd`FSPS_ROW_WORDS) begin
                            state_reg <= ST_WAIT;
                            cnt_reg   <= ROW_CYC - `FSPS_ROW_WORDS;
                        end
                    end
                end
                ST_WAIT: begin
                    if (cnt_reg <= 32'd1) begin
                        state_reg <= ST_DONE;
                    end else begin
                        cnt_reg <= cnt_reg - 32'd1;
                    end
                end
                ST_DONE: begin
                    go_reg     <= 1'b0;
                    CORE_STALL <= 1'b0;
                    state_reg  <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Read channel: one read at a time, answered the cycle after acceptance.
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= 2'b00;
        end else begin
            S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= 2'b00;
                case (S_AXI_ARADDR)
                    `FSPS_OFF_CTRL:   S_AXI_RDATA <= {16'h0000, go_reg, wen_reg, serr_reg,
                                                      6'h00, erase_reg, 2'b00, opsel_reg};
                    `FSPS_OFF_KEY:    S_AXI_RDATA <= 32'h0000_0000;
                    `FSPS_OFF_TPSEL:  S_AXI_RDATA <= {24'h000000, page_reg};
                    `FSPS_OFF_ADDR:   S_AXI_RDATA <= {16'h0000, ea_reg};
                    `FSPS_OFF_WDATA:  S_AXI_RDATA <= {16'h0000, wdat_reg};
                    `FSPS_OFF_TBLCMD: S_AXI_RDATA <= 32'h0000_0000;
                    `FSPS_OFF_RDATA:  S_AXI_RDATA <= {8'h00, rdat_reg};
                    `FSPS_OFF_STATUS: S_AXI_RDATA <= {27'h0, tbl_busy_reg, rd_lo,
                                                      key_stage_reg == 2'd2, CORE_STALL};
                    `FSPS_OFF_FDATA:  S_AXI_RDATA <= {8'h00, fdat_reg};
                    `FSPS_OFF_FCMD:   S_AXI_RDATA <= 32'h0000_0000;
                    default: begin
                        S_AXI_RDATA <= 32'h0000_0000;
                        S_AXI_RRESP <= 2'b10;
                    end
                endcase
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

//--- verif/fsps_flash_model.sv
/*
 * Behavioural flash array that records what the sequencer writes and erases.
 * Assumes the array port of fsps_top on one clock and 128 modelled words.
 */
`timescale 1ns/1ps
`default_nettype none

module fsps_flash_model (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic        FLASH_WR,
    input  wire logic        FLASH_ERASE,
    input  wire logic [23:0] FLASH_ADDR,
    input  wire logic [23:0] FLASH_DATA,
    input  wire logic [23:0] FLASH_ERASE_LEN,
    output var  logic [31:0] wr_count,
    output var  logic [31:0] erase_count,
    output var  logic [23:0] first_addr,
    output var  logic [23:0] last_addr,
    output var  logic [23:0] erase_len
);
    logic [23:0] mem [0:127];
    logic        wr_prev;

    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            wr_count <= 32'h0;
            erase_count <= 32'h0;
            first_addr <= 24'h0;
            last_addr <= 24'h0;
            erase_len <= 24'h0;
            wr_prev <= 1'b0;
        end else begin
            wr_prev <= FLASH_WR;
            if (FLASH_WR) begin
                mem[FLASH_ADDR[7:1]] <= FLASH_DATA;
                wr_count <= wr_count + 32'h1;
                last_addr <= FLASH_ADDR;
                if (!wr_prev) first_addr <= FLASH_ADDR;
            end
            if (FLASH_ERASE) begin
                for (int i = 0; i < 128; i++) mem[i] <= 24'hffffff;
                erase_count <= erase_count + 32'h1;
                erase_len <= FLASH_ERASE_LEN;
            end
        end
    end
endmodule

`default_nettype wire

//--- verif/fsps_top_properties.sv
/*
 * Checker for the array port and stall timing of the flash sequencer.
 * Assumes it is bound onto fsps_top and handed its word duration.
 */
`timescale 1ns/1ps
`default_nettype none

module fsps_props #(
    parameter WORD_CYC = 10
) (
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic        CORE_STALL,
    input wire logic        FLASH_WR,
    input wire logic        FLASH_ERASE,
    input wire logic [23:0] FLASH_ADDR,
    input wire logic [23:0] FLASH_ERASE_LEN
);
    logic [31:0] stall_cnt;
    logic        act;
    wire logic   wr_hs = S_AXI_WVALID && S_AXI_WREADY;

    // Counts stall cycles and notes whether the array was touched meanwhile.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            stall_cnt <= 32'h0;
            act <= 1'b0;
        end else if (CORE_STALL) begin
            stall_cnt <= stall_cnt + 32'h1;
            act <= act | FLASH_WR | FLASH_ERASE;
        end else begin
            stall_cnt <= 32'h0;
            act <= 1'b0;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    wr_in_stall_a: assert property (FLASH_WR |-> CORE_STALL)
        else $error("array write outside an operation");
    erase_in_stall_a: assert property (FLASH_ERASE |-> CORE_STALL)
        else $error("erase outside an operation");
    erase_span_a: assert property (FLASH_ERASE |->
        (FLASH_ERASE_LEN == 24'h000400 || FLASH_ERASE_LEN == 24'hffffff))
        else $error("erase span wrong");
    page_align_a: assert property (FLASH_ERASE && FLASH_ERASE_LEN == 24'h000400 |->
        FLASH_ADDR[9:0] == 10'h0)
        else $error("page erase not aligned");
    word_even_a: assert property (FLASH_WR |-> !FLASH_ADDR[0])
        else $error("odd array address");
    burst_step_a: assert property (FLASH_WR && $past(FLASH_WR) |->
        FLASH_ADDR == $past(FLASH_ADDR) + 24'h2)
        else $error("row burst address step wrong");
    row_bound_a: assert property (FLASH_WR && $past(FLASH_WR) |->
        FLASH_ADDR[23:7] == $past(FLASH_ADDR[23:7]))
        else $error("row burst crossed a row");
    go_start_a: assert property ($rose(CORE_STALL) |-> $past(wr_hs, 1) || $past(wr_hs, 2)
        || $past(wr_hs, 3) || $past(wr_hs, 4))
        else $error("stall without a register write");
    stall_min_a: assert property ($fell(CORE_STALL) && act |-> stall_cnt >= WORD_CYC)
        else $error("operation shorter than its count");
    stall_end_a: assert property ($rose(CORE_STALL) |-> ##[1:1000] !CORE_STALL)
        else $error("stall never released");
    burst_c: cover property (FLASH_WR && $past(FLASH_WR));
endmodule

bind fsps_top fsps_props #(.WORD_CYC(WORD_CYC)) u_props (
    .CLK(CLK), .RSTN(RSTN), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .CORE_STALL(CORE_STALL), .FLASH_WR(FLASH_WR), .FLASH_ERASE(FLASH_ERASE),
    .FLASH_ADDR(FLASH_ADDR), .FLASH_ERASE_LEN(FLASH_ERASE_LEN));

`default_nettype wire

//--- verif/flash_self_program_sequencer_test.sv
/*
 * Self-checking bench for the flash sequencer: AXI4-Lite register master,
 * operation table, row fill, word program and unlock misuse.
 * Assumes fsps_top, fsps_flash_model and the register header are compiled.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fsps_regs.vh"

module flash_self_program_sequencer_test;
    localparam logic [31:0] GO  = 32'h1 << `FSPS_CTRL_GO;
    localparam logic [31:0] WEN = 32'h1 << `FSPS_CTRL_WEN;
    localparam logic [31:0] ER  = 32'h1 << `FSPS_CTRL_ERASE;
    typedef struct packed {logic er; logic [3:0] op; logic [7:0] wrs; logic ers;
                           logic [23:0] len;} fsps_case_t;
    fsps_case_t rows [8] = '{
        '{1'b0, `FSPS_OP_ROW, 8'd64, 1'b0, 24'h0}, '{1'b0, `FSPS_OP_WORD, 8'd1, 1'b0, 24'h0},
        '{1'b1, `FSPS_OP_PAGE, 8'd0, 1'b1, 24'h000400},
        '{1'b1, `FSPS_OP_BULK, 8'd0, 1'b1, 24'hffffff},
        '{1'b0, `FSPS_OP_PAGE, 8'd0, 1'b0, 24'h0}, '{1'b1, `FSPS_OP_ROW, 8'd0, 1'b0, 24'h0},
        '{1'b1, `FSPS_OP_WORD, 8'd0, 1'b0, 24'h0}, '{1'b0, `FSPS_OP_BULK, 8'd0, 1'b0, 24'h0}};
    logic        CLK = 1'b0;
    logic        RSTN = 1'b0;
    logic [7:0]  awaddr = 8'h0;
    logic [7:0]  araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, stall, fwr, fer;
    logic [1:0]  bresp, rresp, last_resp;
    logic [31:0] rdata, rd_data, wr_count, erase_count, n_wr, n_er;
    logic [23:0] faddr, fdata, flen, first_addr, last_addr, erase_len, p;
    int          bad_count = 0;
    int          checked = 0;

    always #12.5 CLK = ~CLK;

    fsps_top #(.ROW_CYC(100), .WORD_CYC(10), .PAGE_CYC(200), .BULK_CYC(400)) dut (
        .CLK(CLK), .RSTN(RSTN), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .CORE_STALL(stall), .FLASH_WR(fwr), .FLASH_ERASE(fer), .FLASH_ADDR(faddr),
        .FLASH_DATA(fdata), .FLASH_ERASE_LEN(flen));

    fsps_flash_model flash (
        .CLK(CLK), .RSTN(RSTN), .FLASH_WR(fwr), .FLASH_ERASE(fer), .FLASH_ADDR(faddr),
        .FLASH_DATA(fdata), .FLASH_ERASE_LEN(flen), .wr_count(wr_count),
        .erase_count(erase_count), .first_addr(first_addr), .last_addr(last_addr),
        .erase_len(erase_len));

    function automatic logic [23:0] pat(input int i);
        return {8'h40 + 8'(i), 8'hc3 ^ 8'(i), 8'(i)};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge CLK);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        last_resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge CLK);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge CLK);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd_data = rdata;
        last_resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic go(input logic [31:0] c);
        wr(`FSPS_OFF_KEY, {24'h0, `FSPS_KEY_FIRST});
        wr(`FSPS_OFF_KEY, {24'h0, `FSPS_KEY_SECOND});
        wr(`FSPS_OFF_CTRL, c);
    endtask

    task automatic wait_idle;
        repeat (3) @(posedge CLK);
        while (stall !== 1'b0) @(posedge CLK);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge CLK);
        bad_count++;
        final_report();
    end

    initial begin
        repeat (5) @(posedge CLK);
        RSTN <= 1'b1;
        rd(`FSPS_OFF_CTRL);
        check("ctrl reset", rd_data, `FSPS_CTRL_RESET);
        wr(`FSPS_OFF_KEY, {24'h0, `FSPS_KEY_FIRST});
        check("write resp", last_resp, 2'b00);
        rd(`FSPS_OFF_KEY);
        check("key reads zero", rd_data, 32'h0);
        rd(8'h40);
        check("unmapped resp", last_resp, 2'b10);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            n_wr = wr_count;
            n_er = erase_count;
            go(GO | WEN | (rows[i].er ? ER : 32'h0) | 32'(rows[i].op));
            @(negedge CLK);
            if (rows[i].wrs != 0 || rows[i].ers) check("stall held", stall, 1'b1);
            wait_idle();
            check("array writes", wr_count - n_wr, 32'(rows[i].wrs));
            check("array erases", erase_count - n_er, 32'(rows[i].ers));
            if (rows[i].ers) check("erase span", erase_len, rows[i].len);
            rd(`FSPS_OFF_CTRL);
            check("go cleared", rd_data[15], 1'b0);
            check("no error", rd_data[13], 1'b0);
        end
        $display("operation table done");
        wr(`FSPS_OFF_TPSEL, 32'h01);
        n_wr = wr_count;
        for (int i = 0; i < 64; i++) begin
            p = pat(i);
            wr(`FSPS_OFF_ADDR, 32'h0100 + 32'(2 * i));
            wr(`FSPS_OFF_WDATA, {16'h0, p[15:0]});
            wr(`FSPS_OFF_TBLCMD, 32'h1);
            wr(`FSPS_OFF_WDATA, {24'h0, p[23:16]});
            wr(`FSPS_OFF_TBLCMD, 32'h3);
        end
        wr(`FSPS_OFF_ADDR, 32'h010b);
        wr(`FSPS_OFF_WDATA, 32'hee);
        wr(`FSPS_OFF_TBLCMD, 32'h5);
        wr(`FSPS_OFF_ADDR, 32'h010a);
        wr(`FSPS_OFF_WDATA, 32'h77);
        wr(`FSPS_OFF_TBLCMD, 32'h7);
        check("table writes only buffer", wr_count - n_wr, 32'h0);
        wr(`FSPS_OFF_ADDR, 32'h0153);
        go(GO | WEN | `FSPS_OP_ROW);
        wait_idle();
        check("row start", first_addr, 24'h010100);
        check("row end", last_addr, 24'h01017e);
        for (int i = 0; i < 64; i++) begin
            p = pat(i);
            if (i == 5) p[23:8] = 16'h77ee;
            check("row word", flash.mem[i], p);
        end
        $display("row test done");
        wr(`FSPS_OFF_FDATA, 32'h00abcdef);
        wr(`FSPS_OFF_TPSEL, 32'h02);
        wr(`FSPS_OFF_ADDR, 32'h0046);
        go(GO | WEN | `FSPS_OP_WORD);
        wait_idle();
        check("word address", last_addr, 24'h020046);
        check("word data", flash.mem[7'h23], 24'habcdef);
        $display("word test done");
        for (int k = 0; k < 4; k++) begin
            if (k == 3) go(GO | WEN | `FSPS_OP_WORD);
            if (k == 3) wait_idle();
            n_wr = wr_count;
            if (k == 1 || k == 2) wr(`FSPS_OFF_KEY, {24'h0, `FSPS_KEY_FIRST});
            if (k == 1) wr(`FSPS_OFF_TPSEL, 32'h02);
            if (k == 1 || k == 2) wr(`FSPS_OFF_KEY, {24'h0, `FSPS_KEY_SECOND});
            wr(`FSPS_OFF_CTRL, (k == 2) ? (GO | `FSPS_OP_WORD) : (GO | WEN | `FSPS_OP_WORD));
            repeat (4) @(posedge CLK);
            @(negedge CLK);
            check("no stall", stall, 1'b0);
            check("no array write", wr_count - n_wr, 32'h0);
            rd(`FSPS_OFF_CTRL);
            check("error set", rd_data[13], 1'b1);
            wr(`FSPS_OFF_CTRL, 32'h0);
            rd(`FSPS_OFF_CTRL);
            check("error cleared", rd_data[13], 1'b0);
        end
        $display("sequence error test done");
        go(GO | WEN | ER | `FSPS_OP_BULK);
        @(posedge CLK);
        RSTN <= 1'b0;
        repeat (5) @(posedge CLK);
        RSTN <= 1'b1;
        rd(`FSPS_OFF_CTRL);
        check("ctrl after reset", rd_data, `FSPS_CTRL_RESET);
        check("stall after reset", stall, 1'b0);
        $display("mid-run reset test done");
        final_report();
    end
endmodule

`default_nettype wire
